// ===== dv/tb_ucmir_core.sv
// Top bench: register tasks, remote device and checker around the serial port.
// Assumes divisor one, so a character takes under 200 clocks.
`timescale 1ns/1ps
`include "ucmir_regs.svh"
module tb_ucmir_core;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic rx_dma_end = 1'b0;
  logic par_on = 1'b1;
  logic [31:0] rd_data;
  logic sin;
  logic sout;
  logic irq;
  logic [7:0] got_byte;
  logic got_par;
  logic got_stop;
  logic [7:0] n_fr;
  logic [7:0] base;
  int miscompares = 0;
  int n_compared = 0;
  always #2 clk_sys = ~clk_sys;
  ucmir_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .serial_in_pin(sin),
    .serial_out_pin(sout), .irq(irq), .rx_dma_end(rx_dma_end), .tx_dma_end(rx_dma_end),
    .tx_dma_buffer_empty(rx_dma_end), .rx_dma_buffer_full(rx_dma_end));
  ucmir_remote peer (.clk_sys(clk_sys), .par_on(par_on), .rx_line(sout), .tx_line(sin),
    .got_byte(got_byte), .got_par(got_par), .got_stop(got_stop), .n_frames(n_fr));
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk("register", e, rd_data & m);
  endtask
  // Waits for the remote to have seen n frames, bounded by 2000 clocks, about eleven characters
  task automatic wt(input logic [7:0] n);
    for (int i = 0; i < 2000 && n_fr !== n; i++)
      @(posedge clk_sys);
    chk("frames", {24'h0, n}, {24'h0, n_fr});
  endtask
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(`UCMIR_ADDR_MODE, 32'h0, 32'hFFFFFFFF);
    wr(`UCMIR_ADDR_IMASK, 32'hFFFFFFFF);
    rd(`UCMIR_ADDR_IMASK, 32'h0, 32'hFFFFFFFF);
    rd(32'h400E0624, 32'h0, 32'hFFFFFFFF);
    wr(`UCMIR_ADDR_IEN, 32'hFFFFFFFF);
    rd(`UCMIR_ADDR_IMASK, 32'h00001AFB, 32'hFFFFFFFF);
    wr(`UCMIR_ADDR_IDIS, 32'h1);
    wr(`UCMIR_ADDR_IEN, 32'h0);
    rd(`UCMIR_ADDR_IMASK, 32'h00001AFA, 32'hFFFFFFFF);
    wr(`UCMIR_ADDR_IDIS, 32'hFFFFFFF7);
    rd(`UCMIR_ADDR_IMASK, 32'h8, 32'hFFFFFFFF);
    rx_dma_end <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    rd(`UCMIR_ADDR_STAT, 32'h00001818, 32'h00001818);
    wr(`UCMIR_ADDR_IDIS, 32'h8);
    repeat (3) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    rx_dma_end <= 1'b0;
    wr(`UCMIR_ADDR_MODE, 32'hFFFFFFFF);
    rd(`UCMIR_ADDR_MODE, 32'h0000CE10, 32'hFFFFFFFF);
    wr(`UCMIR_ADDR_BAUD, 32'h1);
    wr(`UCMIR_ADDR_MODE, 32'h10);
    wr(`UCMIR_ADDR_CMD, 32'h30);
    peer.send_char(8'hA5, 1'b1, 1'b0);
    rd(`UCMIR_ADDR_STAT, 32'h0, 32'h1);
    wr(`UCMIR_ADDR_CMD, 32'h10);
    peer.send_char(8'hA5, 1'b1, 1'b0);
    rd(`UCMIR_ADDR_STAT, 32'h1, 32'hE1);
    rd(`UCMIR_ADDR_RHR, 32'hA5, 32'hFF);
    peer.send_char(8'hA5, 1'b1, 1'b1);
    rd(`UCMIR_ADDR_STAT, 32'h81, 32'h81);
    rd(`UCMIR_ADDR_RHR, 32'hA5, 32'hFF);
    wr(`UCMIR_ADDR_CMD, 32'h100);
    rd(`UCMIR_ADDR_STAT, 32'h0, 32'hE1);
    // Reset lands mid-character so the abort is really exercised
    fork
      peer.send_char(8'h5A, 1'b1, 1'b0);
      begin
        repeat (60) @(posedge clk_sys);
        wr(`UCMIR_ADDR_CMD, 32'h4);
      end
    join
    rd(`UCMIR_ADDR_STAT, 32'h0, 32'h1);
    wr(`UCMIR_ADDR_CMD, 32'h10);
    fork
      peer.send_char(8'h5A, 1'b1, 1'b0);
      begin
        repeat (60) @(posedge clk_sys);
        wr(`UCMIR_ADDR_CMD, 32'h20);
      end
    join
    rd(`UCMIR_ADDR_STAT, 32'h1, 32'h1);
    rd(`UCMIR_ADDR_RHR, 32'h5A, 32'hFF);
    wr(`UCMIR_ADDR_CMD, 32'h50);
    for (int p = 0; p < 5; p++)
    begin
      par_on <= (p < 4);
      wr(`UCMIR_ADDR_MODE, p << 9);
      base = n_fr;
      wr(`UCMIR_ADDR_THR, 32'hA5);
      wt(base + 8'h1);
      chk("byte", 32'hA5, {24'h0, got_byte});
      chk("stop", 32'h1, {31'h0, got_stop});
      if (p < 4)
        chk("parity", (p == 1 || p == 3), {31'h0, got_par});
    end
    par_on <= 1'b1;
    for (int m = 1; m < 4; m += 2)
    begin
      wr(`UCMIR_ADDR_MODE, m << 14);
      base = n_fr;
      peer.send_char(8'h3C, 1'b1, 1'b0);
      wt(base + 8'h1);
      chk("mirror", 32'h3C, {24'h0, got_byte});
    end
    wr(`UCMIR_ADDR_MODE, 32'h8000);
    rd(`UCMIR_ADDR_RHR, 32'h3C, 32'hFF);
    base = n_fr;
    wr(`UCMIR_ADDR_THR, 32'h69);
    repeat (250) @(posedge clk_sys);
    wt(base);
    rd(`UCMIR_ADDR_RHR, 32'h69, 32'hFF);
    wr(`UCMIR_ADDR_MODE, 32'h0);
    base = n_fr;
    wr(`UCMIR_ADDR_THR, 32'h11);
    wr(`UCMIR_ADDR_THR, 32'h22);
    wr(`UCMIR_ADDR_THR, 32'h33);
    rd(`UCMIR_ADDR_STAT, 32'h0, 32'h2);
    wr(`UCMIR_ADDR_THR, 32'h44);
    wr(`UCMIR_ADDR_CMD, 32'h80);
    wt(base + 8'h3);
    chk("byte", 32'h33, {24'h0, got_byte});
    repeat (300) @(posedge clk_sys);
    wt(base + 8'h3);
    wr(`UCMIR_ADDR_CMD, 32'h40);
    base = n_fr;
    wr(`UCMIR_ADDR_THR, 32'h55);
    wr(`UCMIR_ADDR_CMD, 32'h8);
    repeat (300) @(posedge clk_sys);
    wt(base);
    give_verdict();
  end
endmodule // tb_ucmir_core
bind ucmir_core ucmir_core_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .irq(irq),
  .rx_dma_end(rx_dma_end));

// ===== dv/ucmir_core_chk.sv
// Checker on the register port and serial pins of the serial port.
// Assumes it is bound to ucmir_core and sees nothing inside it.
`timescale 1ns/1ps
`include "ucmir_regs.svh"
module ucmir_core_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic serial_in_pin,
  input wire logic serial_out_pin,
  input wire logic irq,
  input wire logic rx_dma_end
);
  logic [12:0] msk_q;
  logic [1:0] chm_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // Shadow copies, so reads can be judged without the design's state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      msk_q <= 13'h0;
      chm_q <= 2'h0;
    end
    else if (wr_en)
    begin
      if (addr == `UCMIR_ADDR_IEN)
        msk_q <= msk_q | (wr_data[12:0] & `UCMIR_IRQ_BITS);
      if (addr == `UCMIR_ADDR_IDIS)
        msk_q <= msk_q & ~wr_data[12:0];
      if (addr == `UCMIR_ADDR_MODE)
        chm_q <= wr_data[15:14];
    end
  end
  sequence s_mode_wr;
    wr_en && addr == `UCMIR_ADDR_MODE;
  endsequence
  sequence s_mode_rd;
    rd_en && addr == `UCMIR_ADDR_MODE;
  endsequence
  a_rd_quiet: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside read cycle");
  a_mask_view: assert property (rd_en && addr == `UCMIR_ADDR_IMASK
    |=> rd_data == {19'h0, $past(msk_q)}) else $error("mask read wrong");
  a_mode_back: assert property (s_mode_wr ##2 s_mode_rd
    |=> rd_data == ($past(wr_data, 3) & 32'h0000CE10)) else $error("mode read wrong");
  a_unmapped_zero: assert property (rd_en && addr > `UCMIR_ADDR_BAUD |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_irq_raised: assert property ((rx_dma_end && msk_q[3]) [*3] |-> irq)
    else $error("irq missing");
  a_irq_quiet: assert property ((msk_q == 13'h0) [*3] |-> !irq)
    else $error("irq while all masked");
  a_local_idle: assert property ((chm_q == `UCMIR_CHM_LOCAL) [*3] |-> serial_out_pin)
    else $error("output not idle in local loop");
  a_mirror_fall: assert property ((chm_q == `UCMIR_CHM_ECHO || chm_q == `UCMIR_CHM_REMOTE)
    && $fell(serial_in_pin) |-> ##[1:6] !serial_out_pin) else $error("input not mirrored");
  a_txrst_idle: assert property (wr_en && addr == `UCMIR_ADDR_CMD && wr_data[3]
    && !wr_data[6] && chm_q == `UCMIR_CHM_NORMAL |-> ##3 serial_out_pin [*8])
    else $error("output not idle after transmit reset");
endmodule // ucmir_core_chk

// ===== dv/ucmir_remote.sv
// Remote serial device: sends framed bytes and decodes what arrives.
// Assumes divisor one, so one bit is sixteen clocks; line idle high.
`timescale 1ns/1ps
module ucmir_remote (
  input wire logic clk_sys,
  input wire logic par_on,
  input wire logic rx_line,
  output logic tx_line,
  output logic [7:0] got_byte,
  output logic got_par,
  output logic got_stop,
  output logic [7:0] n_frames
);
  logic [7:0] b;
  task automatic send_char(input logic [7:0] d, input logic pon, input logic pv);
    logic [10:0] f;
    f = pon ? {1'b1, pv, d, 1'b0} : {2'h3, d, 1'b0};
    for (int i = 0; i < (pon ? 11 : 10); i++)
    begin
      @(posedge clk_sys);
      tx_line <= f[i];
      repeat (15) @(posedge clk_sys);
    end
  endtask
  initial
  begin
    tx_line = 1'b1;
    n_frames = 8'h0;
    forever
    begin
      @(posedge clk_sys);
      if (!rx_line)
      begin
        repeat (8) @(posedge clk_sys);
        // Short low pulses are not frames
        if (!rx_line)
        begin
          for (int i = 0; i < 8; i++)
          begin
            repeat (16) @(posedge clk_sys);
            b[i] = rx_line;
          end
          if (par_on)
          begin
            repeat (16) @(posedge clk_sys);
            got_par = rx_line;
          end
          repeat (16) @(posedge clk_sys);
          got_stop = rx_line;
          got_byte = b;
          n_frames = n_frames + 8'h1;
        end
      end
    end
  end
endmodule // ucmir_remote

// ===== hdl/ucmir_core.sv
// Serial port with command, mode, interrupt mask and data registers.
// Assumes a plain register port on clk_sys and an asynchronous serial input pin.
// Contract
// R1 - Receiver reset command resets and disables receiver, aborting the current character.
// R2 - Transmitter reset command resets and disables transmitter at once, aborting transmission.
// R3 - Receiver enable takes effect only when receiver disable is zero in that write.
// R4 - Receiver disable stops receiver; a character in progress finishes first.
// R5 - Transmitter enable takes effect only when transmitter disable is zero.
// R6 - Transmitter disable stops after shifted and waiting characters are sent.
// R7 - Error-clear command clears parity, framing and overrun flags.
// R8 - Filter bit set: line taken as majority of three samples at 16x.
// R9 - Parity field: even, odd, space, mark, or no parity bit.
// R10 - Ones written to interrupt enable set matching mask bits.
// R11 - Ones written to interrupt disable clear matching mask bits.
// R12 - Mask register reads one for each enabled interrupt source.
// R13 - Ten sources share one bit layout across enable, disable and mask.
// R14 - Channel mode field selects normal, echo, local or remote loopback.
// R15 - Interrupt output high while any set status bit is unmasked.
// R16 - Echo mode resends received bits; transmitter runs without driving line.
// R17 - Local loopback feeds transmitter to receiver; output held idle high.
// R18 - Remote loopback connects input pin to output; transmitter and receiver off.
// R19 - Receiver checks parity per setting and flags mismatch.
`timescale 1ns/1ps
`include "ucmir_regs.svh"
module ucmir_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [31:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic irq,
  input wire logic rx_dma_end,
  input wire logic tx_dma_end,
  input wire logic tx_dma_buffer_empty,
  input wire logic rx_dma_buffer_full
);
  ucmir_pkg::ucmir_state_s q;
  ucmir_pkg::ucmir_state_s d;
  logic [12:0] stat;
  logic [31:0] cmd;
  logic tx_run;
  logic rx_run;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;
  logic buf_flush;
  logic rx_src;
  logic rx_val;

  function automatic logic ucmir_par(input logic [7:0] data, input logic [2:0] sel);
    case (sel)
      `UCMIR_PAR_EVEN: ucmir_par = ^data; // R9
      `UCMIR_PAR_ODD: ucmir_par = ~^data; // R9
      `UCMIR_PAR_SPACE: ucmir_par = 1'b0; // R9
      `UCMIR_PAR_MARK: ucmir_par = 1'b1; // R9
      default: ucmir_par = 1'b0;
    endcase
  endfunction

  function automatic logic ucmir_has_par(input logic [2:0] sel);
    ucmir_has_par = sel < `UCMIR_PAR_NONE; // R9
  endfunction

  assign cmd = (wr_en && addr == `UCMIR_ADDR_CMD) ? wr_data : 32'h00000000;
  // Remote loopback takes both engines out of service
  assign tx_run = q.tx_en && q.channel_test_mode != `UCMIR_CHM_REMOTE; // R18
  assign rx_run = q.rx_en && q.channel_test_mode != `UCMIR_CHM_REMOTE; // R18
  assign buf_in_valid = wr_en && addr == `UCMIR_ADDR_THR && q.tx_en && !q.tx_dis_pend;
  assign buf_out_ready = tx_run && q.tx_phase == ucmir_pkg::UCMIR_IDLE;
  assign buf_flush = cmd[`UCMIR_CMD_TXRST]; // R2
  assign rx_src = (q.channel_test_mode == `UCMIR_CHM_LOCAL) ? q.tx_line : q.rx_sync; // R17
  assign rx_val = q.filter ? ((q.rx_samp[0] & q.rx_samp[1]) | (q.rx_samp[1] & q.rx_samp[2]) |
                  (q.rx_samp[0] & q.rx_samp[2])) : rx_src; // R8

  assign rd_data = q.rdata;
  assign serial_out_pin = q.pin_out;
  assign irq = q.irq;

  ucmir_pair_buf #(
    .W(8),
    .DEPTH(2)
  ) u_tx_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(buf_flush),
    .in_valid(buf_in_valid),
    .in_data(wr_data[7:0]),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(buf_out_ready)
  );

  always_comb
  begin
    stat = 13'h0000;
    stat[`UCMIR_ST_RX_CHAR_READY] = q.rx_char_ready;
    stat[`UCMIR_ST_TX_HOLDING_FREE] = q.tx_en && !q.tx_dis_pend && buf_in_ready;
    stat[`UCMIR_ST_RX_DMA_END] = rx_dma_end;
    stat[`UCMIR_ST_TX_DMA_END] = tx_dma_end;
    stat[`UCMIR_ST_OVERRUN_FLAG] = q.overrun_flag;
    stat[`UCMIR_ST_FRAME] = q.frame;
    stat[`UCMIR_ST_PARITY_ERROR_FLAG] = q.parity_error_flag;
    stat[`UCMIR_ST_TX_ALL_IDLE] = q.tx_en && q.tx_phase == ucmir_pkg::UCMIR_IDLE && !buf_out_valid;
    stat[`UCMIR_ST_TX_DMA_BUFFER_EMPTY] = tx_dma_buffer_empty;
    stat[`UCMIR_ST_RX_DMA_BUFFER_FULL] = rx_dma_buffer_full;
  end

  always_comb
  begin
    d = q;
    // Baud divider; zero divisor stops the bit clock
    if (q.baud_div == 16'h0000)
    begin
      d.baud_cnt = 16'h0000;
      d.tick = 1'b0;
    end
    else if (q.baud_cnt >= 16'(q.baud_div - 16'h0001))
    begin
      d.baud_cnt = 16'h0000;
      d.tick = 1'b1;
    end
    else
    begin
      d.baud_cnt = 16'(q.baud_cnt + 16'h0001);
      d.tick = 1'b0;
    end

    // Register reads, data valid for one cycle only
    d.rdata = 32'h00000000;
    if (rd_en)
    begin
      case (addr)
        `UCMIR_ADDR_MODE:
        begin
          d.rdata[`UCMIR_MODE_FILTER] = q.filter;
          d.rdata[`UCMIR_MODE_PAR_LO +: 3] = q.parity;
          d.rdata[`UCMIR_MODE_CHM_LO +: 2] = q.channel_test_mode;
        end
        `UCMIR_ADDR_IMASK: d.rdata[12:0] = q.imask; // R12
        `UCMIR_ADDR_STAT: d.rdata[12:0] = stat;
        `UCMIR_ADDR_RHR: d.rdata[7:0] = q.rx_hold;
        `UCMIR_ADDR_BAUD: d.rdata[15:0] = q.baud_div;
        default: d.rdata = 32'h00000000;
      endcase
      if (addr == `UCMIR_ADDR_RHR)
        d.rx_char_ready = 1'b0;
    end

    // Register writes
    if (wr_en)
    begin
      case (addr)
        `UCMIR_ADDR_MODE:
        begin
          d.filter = wr_data[`UCMIR_MODE_FILTER]; // R8
          d.parity = wr_data[`UCMIR_MODE_PAR_LO +: 3]; // R9
          d.channel_test_mode = wr_data[`UCMIR_MODE_CHM_LO +: 2]; // R14
        end
        `UCMIR_ADDR_IEN: d.imask = q.imask | (wr_data[12:0] & `UCMIR_IRQ_BITS); // R10 R13
        `UCMIR_ADDR_IDIS: d.imask = q.imask & ~(wr_data[12:0] & `UCMIR_IRQ_BITS); // R11 R13
        `UCMIR_ADDR_BAUD: d.baud_div = wr_data[15:0];
        default: d.imask = q.imask;
      endcase
    end

    // Clear comes before the receiver so a new error wins
    if (cmd[`UCMIR_CMD_CLRERR])
    begin
      d.overrun_flag = 1'b0; // R7
      d.frame = 1'b0; // R7
      d.parity_error_flag = 1'b0; // R7
    end

    // Receive line: two-flop synchroniser, then optional three-sample window
    d.rx_meta = serial_in_pin;
    d.rx_sync = q.rx_meta;
    if (q.tick)
      d.rx_samp = {q.rx_samp[1:0], rx_src}; // R8

    if (!rx_run)
      d.rx_phase = ucmir_pkg::UCMIR_IDLE;
    else if (q.tick)
    begin
      d.rx_sub = 4'(q.rx_sub + 4'h1);
      case (q.rx_phase)
        ucmir_pkg::UCMIR_IDLE:
        begin
          d.rx_sub = 4'h0;
          if (!rx_val)
            d.rx_phase = ucmir_pkg::UCMIR_START;
        end
        ucmir_pkg::UCMIR_START:
        begin
          // Glitch shorter than half a bit is not a start bit
          if (q.rx_sub == `UCMIR_SUB_MID && rx_val)
            d.rx_phase = ucmir_pkg::UCMIR_IDLE;
          else if (q.rx_sub == `UCMIR_SUB_LAST)
          begin
            d.rx_phase = ucmir_pkg::UCMIR_DATA;
            d.rx_cnt = 3'h0;
          end
        end
        ucmir_pkg::UCMIR_DATA:
        begin
          if (q.rx_sub == `UCMIR_SUB_MID)
            d.rx_shift = {rx_val, q.rx_shift[7:1]};
          if (q.rx_sub == `UCMIR_SUB_LAST)
          begin
            d.rx_cnt = 3'(q.rx_cnt + 3'h1);
            if (q.rx_cnt == `UCMIR_BIT_LAST)
              d.rx_phase = ucmir_has_par(q.parity) ? ucmir_pkg::UCMIR_PARITY :
                           ucmir_pkg::UCMIR_STOP; // R9
          end
        end
        ucmir_pkg::UCMIR_PARITY:
        begin
          if (q.rx_sub == `UCMIR_SUB_MID)
            d.rx_parbit = rx_val;
          if (q.rx_sub == `UCMIR_SUB_LAST)
            d.rx_phase = ucmir_pkg::UCMIR_STOP;
        end
        ucmir_pkg::UCMIR_STOP:
        begin
          if (q.rx_sub == `UCMIR_SUB_MID)
          begin
            d.rx_hold = q.rx_shift;
            d.rx_char_ready = 1'b1;
            d.overrun_flag = d.overrun_flag | q.rx_char_ready;
            d.frame = d.frame | !rx_val;
            d.parity_error_flag = d.parity_error_flag | (ucmir_has_par(q.parity) &&
                     q.rx_parbit != ucmir_par(q.rx_shift, q.parity)); // R19
            d.rx_phase = ucmir_pkg::UCMIR_IDLE;
            if (q.rx_dis_pend)
            begin
              d.rx_en = 1'b0; // R4
              d.rx_dis_pend = 1'b0;
            end
          end
        end
        default: d.rx_phase = ucmir_pkg::UCMIR_IDLE;
      endcase
    end

    // Transmitter; in echo mode it still runs but never reaches the pin
    if (buf_out_valid && buf_out_ready)
    begin
      d.tx_shift = buf_out_data;
      d.tx_parbit = ucmir_par(buf_out_data, q.parity); // R9
      d.tx_phase = ucmir_pkg::UCMIR_START;
      d.tx_sub = 4'h0;
    end
    else if (!tx_run)
      d.tx_phase = ucmir_pkg::UCMIR_IDLE;
    else if (q.tick && q.tx_phase != ucmir_pkg::UCMIR_IDLE)
    begin
      d.tx_sub = 4'(q.tx_sub + 4'h1);
      if (q.tx_sub == `UCMIR_SUB_LAST)
      begin
        case (q.tx_phase)
          ucmir_pkg::UCMIR_START:
          begin
            d.tx_phase = ucmir_pkg::UCMIR_DATA;
            d.tx_cnt = 3'h0;
          end
          ucmir_pkg::UCMIR_DATA:
          begin
            d.tx_shift = {1'b0, q.tx_shift[7:1]};
            d.tx_cnt = 3'(q.tx_cnt + 3'h1);
            if (q.tx_cnt == `UCMIR_BIT_LAST)
              d.tx_phase = ucmir_has_par(q.parity) ? ucmir_pkg::UCMIR_PARITY :
                           ucmir_pkg::UCMIR_STOP; // R9
          end
          ucmir_pkg::UCMIR_PARITY: d.tx_phase = ucmir_pkg::UCMIR_STOP;
          default: d.tx_phase = ucmir_pkg::UCMIR_IDLE;
        endcase
      end
    end
    case (d.tx_phase)
      ucmir_pkg::UCMIR_START: d.tx_line = 1'b0;
      ucmir_pkg::UCMIR_DATA: d.tx_line = d.tx_shift[0];
      ucmir_pkg::UCMIR_PARITY: d.tx_line = d.tx_parbit;
      default: d.tx_line = 1'b1;
    endcase
    // Disable waits for shifter and buffer to drain
    if (q.tx_dis_pend && q.tx_phase == ucmir_pkg::UCMIR_IDLE && !buf_out_valid &&
        !(buf_out_valid && buf_out_ready))
    begin
      d.tx_en = 1'b0; // R6
      d.tx_dis_pend = 1'b0;
    end

    // Commands; resets follow the engines so they override them, and enables come last
    if (cmd[`UCMIR_CMD_RX_DISABLE_CMD])
    begin
      if (q.rx_phase == ucmir_pkg::UCMIR_IDLE)
        d.rx_en = 1'b0; // R4
      else
        d.rx_dis_pend = 1'b1; // R4
    end
    if (cmd[`UCMIR_CMD_TX_DISABLE_CMD])
    begin
      if (q.tx_phase == ucmir_pkg::UCMIR_IDLE && !buf_out_valid)
        d.tx_en = 1'b0; // R6
      else
        d.tx_dis_pend = 1'b1; // R6
    end
    if (cmd[`UCMIR_CMD_RXRST])
    begin
      d.rx_en = 1'b0; // R1
      d.rx_dis_pend = 1'b0;
      d.rx_phase = ucmir_pkg::UCMIR_IDLE; // R1
      d.rx_sub = 4'h0;
    end
    if (cmd[`UCMIR_CMD_TXRST])
    begin
      d.tx_en = 1'b0; // R2
      d.tx_dis_pend = 1'b0;
      d.tx_phase = ucmir_pkg::UCMIR_IDLE; // R2
      d.tx_line = 1'b1;
    end
    if (cmd[`UCMIR_CMD_RX_ENABLE_CMD] && !cmd[`UCMIR_CMD_RX_DISABLE_CMD])
    begin
      d.rx_en = 1'b1; // R3
      d.rx_dis_pend = 1'b0;
    end
    if (cmd[`UCMIR_CMD_TX_ENABLE_CMD] && !cmd[`UCMIR_CMD_TX_DISABLE_CMD])
    begin
      d.tx_en = 1'b1; // R5
      d.tx_dis_pend = 1'b0;
    end

    // Output pin per channel mode
    case (q.channel_test_mode)
      `UCMIR_CHM_ECHO: d.pin_out = q.rx_sync; // R16
      `UCMIR_CHM_LOCAL: d.pin_out = 1'b1; // R17
      `UCMIR_CHM_REMOTE: d.pin_out = q.rx_sync; // R18
      default: d.pin_out = q.tx_line; // R14
    endcase

    d.irq = |(stat & q.imask); // R15
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.rx_meta <= 1'b1;
      q.rx_sync <= 1'b1;
      q.rx_samp <= 3'h7;
      q.tx_line <= 1'b1;
      q.pin_out <= 1'b1;
    end
    else
      q <= d;
  end
endmodule // ucmir_core

// ===== hdl/ucmir_pair_buf.sv
// Small ready/valid buffer between the holding register port and the shifter.
// Assumes one clock, synchronous active-low reset, flush from the same domain.
`timescale 1ns/1ps
module ucmir_pair_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] cnt;
  } ucmir_buf_s;

  ucmir_buf_s q;
  ucmir_buf_s d;
  logic push;
  logic pop;

  assign in_ready = q.cnt != (AW + 1)'(DEPTH);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr_ptr] = in_data;
      d.wr_ptr = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr_ptr + 1'b1);
    end
    if (pop)
      d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(q.rd_ptr + 1'b1);
    // Simultaneous push and pop keeps the count
    if (push && !pop)
      d.cnt = (AW + 1)'(q.cnt + 1'b1);
    else if (pop && !push)
      d.cnt = (AW + 1)'(q.cnt - 1'b1);
    if (flush)
      d = '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end
endmodule // ucmir_pair_buf

// ===== include/ucmir_pkg.sv
// Types shared by the serial port control block.
// Assumes widths fixed at eight data bits and thirteen status positions.
package ucmir_pkg;

  typedef enum logic [2:0] {
    UCMIR_IDLE,
    UCMIR_START,
    UCMIR_DATA,
    UCMIR_PARITY,
    UCMIR_STOP
  } ucmir_phase_e;

  typedef struct packed {
    logic [31:0] rdata;
    logic filter;
    logic [2:0] parity;
    logic [1:0] channel_test_mode;
    logic [15:0] baud_div;
    logic [15:0] baud_cnt;
    logic tick;
    logic [12:0] imask;
    logic rx_en;
    logic rx_dis_pend;
    logic tx_en;
    logic tx_dis_pend;
    logic rx_meta;
    logic rx_sync;
    logic [2:0] rx_samp;
    ucmir_phase_e rx_phase;
    logic [3:0] rx_sub;
    logic [2:0] rx_cnt;
    logic [7:0] rx_shift;
    logic rx_parbit;
    logic [7:0] rx_hold;
    logic rx_char_ready;
    logic overrun_flag;
    logic frame;
    logic parity_error_flag;
    ucmir_phase_e tx_phase;
    logic [3:0] tx_sub;
    logic [2:0] tx_cnt;
    logic [7:0] tx_shift;
    logic tx_parbit;
    logic tx_line;
    logic pin_out;
    logic irq;
  } ucmir_state_s;

endpackage

// ===== include/ucmir_regs.svh
// Register addresses, field positions, reset values and timing counts of the serial port.
// Assumes 32-bit word-aligned register addresses on the plain register port.
`ifndef UCMIR_REGS_SVH
`define UCMIR_REGS_SVH

`define UCMIR_ADDR_CMD 32'h400E0600
`define UCMIR_ADDR_MODE 32'h400E0604
`define UCMIR_ADDR_IEN 32'h400E0608
`define UCMIR_ADDR_IDIS 32'h400E060C
`define UCMIR_ADDR_IMASK 32'h400E0610
`define UCMIR_ADDR_STAT 32'h400E0614
`define UCMIR_ADDR_RHR 32'h400E0618
`define UCMIR_ADDR_THR 32'h400E061C
`define UCMIR_ADDR_BAUD 32'h400E0620

`define UCMIR_CMD_RXRST 2
`define UCMIR_CMD_TXRST 3
`define UCMIR_CMD_RX_ENABLE_CMD 4
`define UCMIR_CMD_RX_DISABLE_CMD 5
`define UCMIR_CMD_TX_ENABLE_CMD 6
`define UCMIR_CMD_TX_DISABLE_CMD 7
`define UCMIR_CMD_CLRERR 8

`define UCMIR_MODE_FILTER 4
`define UCMIR_MODE_PAR_LO 9
`define UCMIR_MODE_CHM_LO 14

`define UCMIR_PAR_EVEN 3'h0
`define UCMIR_PAR_ODD 3'h1
`define UCMIR_PAR_SPACE 3'h2
`define UCMIR_PAR_MARK 3'h3
`define UCMIR_PAR_NONE 3'h4

`define UCMIR_CHM_NORMAL 2'h0
`define UCMIR_CHM_ECHO 2'h1
`define UCMIR_CHM_LOCAL 2'h2
`define UCMIR_CHM_REMOTE 2'h3

`define UCMIR_ST_RX_CHAR_READY 0
`define UCMIR_ST_TX_HOLDING_FREE 1
`define UCMIR_ST_RX_DMA_END 3
`define UCMIR_ST_TX_DMA_END 4
`define UCMIR_ST_OVERRUN_FLAG 5
`define UCMIR_ST_FRAME 6
`define UCMIR_ST_PARITY_ERROR_FLAG 7
`define UCMIR_ST_TX_ALL_IDLE 9
`define UCMIR_ST_TX_DMA_BUFFER_EMPTY 11
`define UCMIR_ST_RX_DMA_BUFFER_FULL 12
`define UCMIR_IRQ_BITS 13'h1AFB

`define UCMIR_MODE_RESET 32'h00000000
`define UCMIR_BAUD_RESET 16'h0000
`define UCMIR_SUB_MID 4'h7
`define UCMIR_SUB_LAST 4'hF
`define UCMIR_BIT_LAST 3'h7

`endif
